//--- rtl/nv_access_pkg.sv
// constants and types for the nonvolatile memory access control block
package nv_access_pkg;

    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] KEY_OFFSET = 32'h0000_0004;
    localparam logic [31:0] STAT_OFFSET = 32'h0000_0008;

    localparam int SPACE_BIT = 7;
    localparam int ABORT_BIT = 3;
    localparam int PERMIT_BIT = 2;
    localparam int LAUNCH_BIT = 1;
    localparam int READ_BIT = 0;
    localparam int DONE_BIT = 0;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    localparam logic SPACE_RESET = 1'b0;
    localparam logic PERMIT_RESET = 1'b0;
    localparam logic DONE_RESET = 1'b0;
    localparam logic LAUNCH_RESET = 1'b0;
    localparam logic READ_RESET = 1'b0;
    localparam logic START_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_HALF,
        KEY_OPEN
    } key_state_e;

endpackage : nv_access_pkg

//--- rtl/nv_access_ctrl.sv
// control register logic of the nonvolatile memory access unit
//
// Added by the designer: register access over APB and the register offsets.
module nv_access_ctrl
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire nv_access_pkg::apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // memory engine
    output logic memory_space_select_o,
    output logic write_start_o,
    output logic read_start_o,
    input wire logic write_done_i
);
    import nv_access_pkg::*;

    // unlock sequencer state
    key_state_e key_reg, key_next;
    // control register bits
    logic space_reg, space_next;
    logic abort_reg, abort_next;
    logic permit_reg, permit_next;
    logic launch_reg, launch_next;
    logic read_reg, read_next;
    logic wstart_reg, wstart_next;
    // status flag and read data
    logic done_reg, done_next;
    logic [31:0] rdata_reg, rdata_next;

    logic access, wr_en, rd_setup, set_launch, set_read, write_end;
    logic wr_ctrl, wr_key, wr_stat;
    logic [7:0] wbyte;

    function automatic logic is_mapped(input logic [31:0] a);
        return a == CTRL_OFFSET || a == KEY_OFFSET || a == STAT_OFFSET;
    endfunction : is_mapped

    assign access = apb_i.psel && apb_i.penable;
    assign wr_en = access && apb_i.pwrite && is_mapped(apb_i.paddr);
    assign rd_setup = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
    assign wbyte = apb_i.pwdata[7:0];
    assign wr_ctrl = wr_en && apb_i.paddr == CTRL_OFFSET;
    assign wr_key = wr_en && apb_i.paddr == KEY_OFFSET;
    assign wr_stat = wr_en && apb_i.paddr == STAT_OFFSET;
    assign pready_o = 1'b1;
    assign pslverr_o = access && !is_mapped(apb_i.paddr);

    // launch needs key sequence, permit and data space
    assign set_launch = wr_ctrl && wbyte[LAUNCH_BIT] && key_reg == KEY_OPEN
        && permit_reg && !space_reg && !launch_reg;
    assign set_read = wr_ctrl && wbyte[READ_BIT];
    assign write_end = launch_reg && write_done_i;

    // unlock sequencer: any write to a mapped register other than the next key step starts over
    always_comb
    begin
        key_next = key_reg;
        if (wr_en)
        begin
            key_next = KEY_IDLE;
            if (wr_key && wbyte == KEY_FIRST)
            begin
                key_next = KEY_HALF;
            end
            else if (wr_key && wbyte == KEY_SECOND && key_reg == KEY_HALF)
            begin
                key_next = KEY_OPEN;
            end
        end
        if (sys_rst_i)
        begin
            key_next = KEY_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        key_reg <= key_next;
    end

    // control register bits and engine strobes
    always_comb
    begin
        space_next = space_reg;
        abort_next = abort_reg;
        permit_next = permit_reg;
        launch_next = launch_reg;
        read_next = set_read;
        wstart_next = set_launch;
        if (wr_ctrl)
        begin
            space_next = wbyte[SPACE_BIT];
            abort_next = wbyte[ABORT_BIT];
            permit_next = wbyte[PERMIT_BIT];
        end
        if (set_launch)
        begin
            launch_next = 1'b1;
        end
        // completion wins over a control write in the same cycle
        if (write_end)
        begin
            launch_next = 1'b0;
            abort_next = 1'b0;
        end
        if (sys_rst_i)
        begin
            // a write cut short by reset is recorded and kept afterwards
            abort_next = launch_reg ? 1'b1 : abort_reg;
            space_next = SPACE_RESET;
            permit_next = PERMIT_RESET;
            launch_next = LAUNCH_RESET;
            read_next = READ_RESET;
            wstart_next = START_RESET;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        space_reg <= space_next;
        abort_reg <= abort_next;
        permit_reg <= permit_next;
        launch_reg <= launch_next;
        read_reg <= read_next;
        wstart_reg <= wstart_next;
    end

    // store done flag: hardware set wins over a software clear
    always_comb
    begin
        done_next = done_reg;
        if (wr_stat && !wbyte[DONE_BIT])
        begin
            done_next = 1'b0;
        end
        if (write_end)
        begin
            done_next = 1'b1;
        end
        if (sys_rst_i)
        begin
            done_next = DONE_RESET;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        done_reg <= done_next;
    end

    // read data is loaded in the setup cycle and held until the next read
    always_comb
    begin
        rdata_next = rdata_reg;
        if (rd_setup)
        begin
            unique case (apb_i.paddr)
                CTRL_OFFSET: rdata_next = {24'h00_0000, space_reg, 3'h0, abort_reg,
                    permit_reg, launch_reg, read_reg};
                STAT_OFFSET: rdata_next = {31'h0000_0000, done_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (sys_rst_i)
        begin
            rdata_next = RDATA_RESET;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        rdata_reg <= rdata_next;
    end

    assign prdata_o = rdata_reg;
    assign memory_space_select_o = space_reg;
    assign write_start_o = wstart_reg;
    assign read_start_o = read_reg;

    a_launch_needs_key: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(launch_reg) |-> $past(key_reg) == KEY_OPEN && $past(permit_reg))
        else $error("launch set without unlock or permit");
    a_prog_launch_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $past(space_reg) && !$past(launch_reg) |-> !launch_reg)
        else $error("launch set with program memory selected");
    a_launch_sticky: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        launch_reg && !write_done_i |=> launch_reg)
        else $error("launch cleared without completion");
    a_done_on_end: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        launch_reg && write_done_i |=> !launch_reg && done_reg && !abort_reg)
        else $error("write end not recorded");
    a_read_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        read_reg |=> !read_reg || $past(set_read))
        else $error("read bit did not self clear");
    a_abort_on_reset: assert property (@(posedge ref_clk_i)
        sys_rst_i && launch_reg |=> abort_reg && !launch_reg)
        else $error("aborted write not flagged");
    a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $past(rd_setup) && $past(apb_i.paddr) == CTRL_OFFSET |-> prdata_o[6:4] == 3'h0)
        else $error("reserved bits not zero");
    a_permit_reset: assert property (@(posedge ref_clk_i)
        sys_rst_i |=> !permit_reg && !launch_reg && !read_reg)
        else $error("reset values wrong");
    a_start_follows: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(launch_reg) |-> write_start_o)
        else $error("write start missing");
    a_key_consumed: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> key_reg == KEY_IDLE)
        else $error("unlock sequence not consumed");
    a_done_kept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        done_reg && !wr_stat |=> done_reg)
        else $error("done flag lost without software clear");
    a_abort_kept: assert property (@(posedge ref_clk_i)
        abort_reg && !wr_ctrl && !write_end |=> abort_reg)
        else $error("abort flag lost");
    a_permit_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wr_ctrl && wbyte[PERMIT_BIT] |=> permit_reg)
        else $error("store permit not written");

    c_write_done: cover property (@(posedge ref_clk_i) launch_reg && write_done_i);
    c_abort: cover property (@(posedge ref_clk_i) sys_rst_i && launch_reg);
    c_read: cover property (@(posedge ref_clk_i) read_start_o);
    c_key_open: cover property (@(posedge ref_clk_i) key_reg == KEY_OPEN);
    c_launch_refused: cover property (@(posedge ref_clk_i)
        wr_ctrl && wbyte[LAUNCH_BIT] && !set_launch);

endmodule : nv_access_ctrl

//--- test/testbench.sv
// self-checking bench for the nonvolatile memory access control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import nv_access_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    apb_req_s apb_i = '0;
    logic write_done_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic memory_space_select_o;
    logic write_start_o;
    logic read_start_o;
    int err_count = 0;
    int checks = 0;
    int ws_cnt = 0;
    int rs_cnt = 0;
    logic [31:0] q;
    logic e;
    nv_access_ctrl nv_access_ctrl_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .memory_space_select_o(memory_space_select_o), .write_start_o(write_start_o),
        .read_start_o(read_start_o), .write_done_i(write_done_i));
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // count cycles each start strobe is high, sampled mid-cycle where it is settled
    always @(negedge ref_clk_i)
    begin
        if (write_start_o === 1'b1) ws_cnt <= ws_cnt + 1;
        if (read_start_o === 1'b1) rs_cnt <= rs_cnt + 1;
    end
    task automatic print_verdict;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, then one idle edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_i.psel <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite <= w;
        apb_i.paddr <= a;
        apb_i.pwdata <= d;
        @(posedge ref_clk_i);
        apb_i.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1)
        begin
            err_count++;
            print_verdict();
        end
        q = prdata_o;
        e = pslverr_o;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask : rd
    task automatic unlock;
        wr(KEY_OFFSET, KEY_FIRST);
        wr(KEY_OFFSET, KEY_SECOND);
    endtask : unlock
    task automatic t_write;
        wr(CTRL_OFFSET, 8'h00);
        rd(CTRL_OFFSET, 8'h00);
        unlock();
        wr(CTRL_OFFSET, 8'h02);
        rd(CTRL_OFFSET, 8'h00);
        wr(CTRL_OFFSET, 8'h04);
        unlock();
        wr(CTRL_OFFSET, 8'h06);
        chk(32'(ws_cnt), 32'h1);
        wr(CTRL_OFFSET, 8'h08);
        rd(CTRL_OFFSET, 8'h0a);
        rd(STAT_OFFSET, 8'h00);
        write_done_i <= 1'b1;
        @(posedge ref_clk_i);
        write_done_i <= 1'b0;
        rd(CTRL_OFFSET, 8'h00);
        rd(STAT_OFFSET, 8'h01);
        wr(STAT_OFFSET, 8'h00);
        rd(STAT_OFFSET, 8'h00);
    endtask : t_write
    task automatic t_refused;
        wr(CTRL_OFFSET, 8'h04);
        wr(KEY_OFFSET, KEY_FIRST);
        wr(CTRL_OFFSET, 8'h04);
        wr(KEY_OFFSET, KEY_SECOND);
        wr(CTRL_OFFSET, 8'h06);
        rd(CTRL_OFFSET, 8'h04);
        wr(CTRL_OFFSET, 8'h84);
        unlock();
        wr(CTRL_OFFSET, 8'h86);
        rd(CTRL_OFFSET, 8'h84);
        chk({31'h0, memory_space_select_o}, 32'h1);
        chk(32'(ws_cnt), 32'h1);
        wr(CTRL_OFFSET, 8'h01);
        rd(CTRL_OFFSET, 8'h00);
        chk({31'h0, memory_space_select_o}, 32'h0);
        chk(32'(rs_cnt), 32'h1);
        apb(1'b0, 32'h0000_000c, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask : t_refused
    task automatic t_abort;
        wr(CTRL_OFFSET, 8'h04);
        unlock();
        wr(CTRL_OFFSET, 8'h06);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(CTRL_OFFSET, 8'h08);
        chk(32'(ws_cnt), 32'h2);
    endtask : t_abort
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_write();
        t_refused();
        t_abort();
        print_verdict();
    end
endmodule : testbench
